// file: src/reset_strap_latch.v
// Reset strap capture, hard-reset open-drain line and AXI4-Lite register slave
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "strap_latch_regs.vh"
module reset_strap_latch (
    input  wire        MCLK,
    input  wire        SYS_RST,
    input  wire        POWER_ON_RESET_N,
    input  wire [3:0]  BOOT_SELECT,
    input  wire        WATCHDOG_STRAP,
    input  wire        HOST_STROBE_POLARITY,
    input  wire        HOST_WIDTH_SELECT,
    input  wire        HARD_RESET_LINE_IN,
    output reg         HARD_RESET_LINE_OUT,
    output reg         HARD_RESET_LINE_OE,
    output reg  [3:0]  BOOT_MODE,
    output reg         WATCHDOG_ENABLE,
    output reg         HOST_STROBE_ACTIVE_HIGH,
    output reg         HOST_PORT_8BIT,
    output reg         STRAPS_VALID,
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Bit 8 is the hard-reset wire, bit 7 power-on reset, bits 6:0 the straps
    wire [8:0] pin_raw;
    wire [8:0] pin_sync;

    assign pin_raw = {HARD_RESET_LINE_IN,
                      POWER_ON_RESET_N,
                      HOST_WIDTH_SELECT,
                      HOST_STROBE_POLARITY,
                      WATCHDOG_STRAP,
                      BOOT_SELECT};

    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
            sync2 u_sync (
                .MCLK    (MCLK),
                .SYS_RST (SYS_RST),
                .d       (pin_raw[gi]),
                .q       (pin_sync[gi])
            );
        end
    endgenerate

    wire [6:0] strap_now;
    wire       por_n;
    wire       hr_level;

    assign strap_now = pin_sync[6:0];
    assign por_n     = pin_sync[7];
    assign hr_level  = pin_sync[8];

    // ****************************************************************
    // Strap capture on release of power-on reset
    // ****************************************************************
    reg       por_prev;
    reg [6:0] strap;
    reg       captured;
    reg       hr_drive;
    reg       hr_seen;

    // Both edges of the strap sampling share the same synchroniser delay, so the
    // straps seen here are those present at the reset edge, give or take one cycle
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            por_prev <= 1'b0;
            strap    <= `STRAP_RESET;
            captured <= 1'b0;
        end else begin
            por_prev <= por_n;
            if (!por_n) begin
                captured <= 1'b0;
            end else if (!por_prev) begin
                strap    <= strap_now;
                captured <= 1'b1;
            end
            // Later pin changes are ignored until power-on reset returns
        end
    end

    // ****************************************************************
    // Decoded configuration outputs
    // ****************************************************************
    wire [3:0] latched_boot;
    wire       latched_wdog;
    wire       latched_polarity;
    wire       latched_width;

    assign latched_boot     = strap[`FLD_BOOT_HI:`FLD_BOOT_LO];
    assign latched_wdog     = strap[`FLD_WDOG];
    assign latched_polarity = strap[`FLD_POLARITY];
    assign latched_width    = strap[`FLD_WIDTH];

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            BOOT_MODE               <= 4'h0;
            WATCHDOG_ENABLE         <= 1'b0;
            HOST_STROBE_ACTIVE_HIGH <= 1'b0;
            HOST_PORT_8BIT          <= 1'b0;
            STRAPS_VALID            <= 1'b0;
        end else begin
            BOOT_MODE               <= latched_boot;
            WATCHDOG_ENABLE         <= captured & latched_wdog;
            HOST_STROBE_ACTIVE_HIGH <= latched_polarity;
            HOST_PORT_8BIT          <= latched_width;
            STRAPS_VALID            <= captured;
        end
    end

    // ****************************************************************
    // Hard-reset open-drain line
    // ****************************************************************
    // Only ever drives low; a high level comes from the board pull-up
    // Pulled during power-on reset too, so the rest of the board is held with us
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            HARD_RESET_LINE_OUT <= 1'b0;
            HARD_RESET_LINE_OE  <= 1'b0;
        end else begin
            HARD_RESET_LINE_OUT <= 1'b0;
            HARD_RESET_LINE_OE  <= hr_drive | ~por_n;
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    reg        aw_held;
    reg        w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    function [7:0] word_addr;
        input [7:0] a;
        begin
            word_addr = {a[7:2], 2'b00};
        end
    endfunction

    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `OFS_STRAP_STATUS) || (a == `OFS_HARD_RESET_LINE_CTRL) ||
                        (a == `OFS_HARD_RESET_LINE_STATUS);
        end
    endfunction

    wire do_write;
    wire do_read;
    wire wr_ctrl;
    wire wr_stat;

    assign do_write = aw_held & w_held & ~S_AXI_BVALID;
    assign do_read  = S_AXI_ARVALID & S_AXI_ARREADY;
    assign wr_ctrl  = do_write && aw_addr == `OFS_HARD_RESET_LINE_CTRL && w_strb[0];
    assign wr_stat  = do_write && aw_addr == `OFS_HARD_RESET_LINE_STATUS && w_strb[0];

    wire [7:0]  ar_word;
    wire [31:0] status_word;
    wire [31:0] ctrl_word;
    wire [31:0] line_word;

    assign ar_word     = word_addr(S_AXI_ARADDR);
    assign status_word = {24'h000000, captured, strap};
    assign ctrl_word   = {31'h00000000, hr_drive};
    assign line_word   = {30'h00000000, hr_seen, hr_level};

    // ****************************************************************
    // Write channels
    // ****************************************************************
    // Address and data are taken independently, so either may come first
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            S_AXI_AWREADY <= 1'b0;
            aw_held       <= 1'b0;
            aw_addr       <= 8'h00;
        end else begin
            S_AXI_AWREADY <= ~aw_held & ~S_AXI_AWREADY & S_AXI_AWVALID;
            if (S_AXI_AWVALID & S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= word_addr(S_AXI_AWADDR);
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            S_AXI_WREADY <= 1'b0;
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
        end else begin
            S_AXI_WREADY <= ~w_held & ~S_AXI_WREADY & S_AXI_WVALID;
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `RESP_OKAY;
        end else begin
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (S_AXI_BVALID & S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Software hard-reset request
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            hr_drive <= 1'b0;
        end else if (wr_ctrl) begin
            hr_drive <= w_data[`FLD_HR_DRIVE];
        end
    end

    // Sticky line-low flag; a new low wins over a clear in the same cycle
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            hr_seen <= 1'b0;
        end else if (!hr_level) begin
            hr_seen <= 1'b1;
        end else if (wr_stat && w_data[`FLD_HR_SEEN]) begin
            hr_seen <= 1'b0;
        end
    end

    // ****************************************************************
    // Read channels
    // ****************************************************************
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            S_AXI_ARREADY <= 1'b0;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
        end
    end

    // Data is sampled at the address handshake and held until taken
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
            S_AXI_RRESP  <= `RESP_OKAY;
        end else begin
            if (do_read) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= is_mapped(ar_word) ? `RESP_OKAY : `RESP_SLVERR;
                case (ar_word)
                    `OFS_STRAP_STATUS: begin
                        S_AXI_RDATA <= status_word;
                    end
                    `OFS_HARD_RESET_LINE_CTRL: begin
                        S_AXI_RDATA <= ctrl_word;
                    end
                    `OFS_HARD_RESET_LINE_STATUS: begin
                        S_AXI_RDATA <= line_word;
                    end
                    default: begin
                        S_AXI_RDATA <= 32'h00000000;
                    end
                endcase
            end else if (S_AXI_RVALID & S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule

// file: src/strap_latch_regs.vh
// Constants for the reset strap capture block: register map, fields and reset values
`ifndef STRAP_LATCH_REGS_VH
`define STRAP_LATCH_REGS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_STRAP_STATUS   8'h00
`define OFS_HARD_RESET_LINE_CTRL    8'h04
`define OFS_HARD_RESET_LINE_STATUS  8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define FLD_BOOT_LO        0
`define FLD_BOOT_HI        3
`define FLD_WDOG           4
`define FLD_POLARITY       5
`define FLD_WIDTH          6
`define FLD_CAPTURED       7
`define FLD_HR_DRIVE       0
`define FLD_HR_LEVEL       0
`define FLD_HR_SEEN        1

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define STRAP_RESET        7'h00
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// file: src/sync2.v
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
module sync2 (
    input  wire MCLK,
    input  wire SYS_RST,
    input  wire d,
    output reg  q
);
    reg meta;

    always @(posedge MCLK) begin
        if (SYS_RST) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// file: tb/board_supervisor.sv
// Board-side model: power-on reset supervisor, strap drivers and hard-reset pull-up
`timescale 1ns/1ps
module board_supervisor (
    input  wire       MCLK,
    input  wire       por_hold,
    input  wire [6:0] cfg,
    input  wire       pull_low,
    input  wire       HARD_RESET_LINE_OE,
    output reg        POWER_ON_RESET_N,
    output wire [3:0] BOOT_SELECT,
    output wire       WATCHDOG_STRAP,
    output wire       HOST_STROBE_POLARITY,
    output wire       HOST_WIDTH_SELECT,
    output wire       HARD_RESET_LINE_IN
);
    reg [6:0] pins;
    reg [2:0] settle;
    assign {HOST_WIDTH_SELECT, HOST_STROBE_POLARITY, WATCHDOG_STRAP, BOOT_SELECT} = pins;
    // Pull-up wins unless an open-drain party sinks the wire
    assign HARD_RESET_LINE_IN = ~(HARD_RESET_LINE_OE | pull_low);
    initial begin
        POWER_ON_RESET_N = 1'b0;
        pins = 7'h00;
        settle = 3'h0;
    end
    always @(posedge MCLK) begin
        pins <= cfg;
        settle <= (cfg != pins) ? 3'h0 : settle + {2'h0, settle != 3'h7};
        // Release only once straps have settled, so the capture edge sees valid levels
        POWER_ON_RESET_N <= ~por_hold & (POWER_ON_RESET_N | (settle == 3'h7));
    end
endmodule

// file: tb/strap_latch_monitor.sv
// Assertion checker for the reset strap capture block
`timescale 1ns/1ps
module strap_latch_monitor (
    input wire       MCLK,
    input wire       SYS_RST,
    input wire       POWER_ON_RESET_N,
    input wire [3:0] BOOT_SELECT,
    input wire       WATCHDOG_STRAP,
    input wire       HOST_STROBE_POLARITY,
    input wire       HOST_WIDTH_SELECT,
    input wire       HARD_RESET_LINE_OUT,
    input wire       HARD_RESET_LINE_OE,
    input wire [3:0] BOOT_MODE,
    input wire       WATCHDOG_ENABLE,
    input wire       HOST_STROBE_ACTIVE_HIGH,
    input wire       HOST_PORT_8BIT,
    input wire       STRAPS_VALID,
    input wire       S_AXI_BVALID,
    input wire       S_AXI_BREADY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // ****
    // Power-on reset phases
    // ****
    // Four low samples flush the synchroniser and the line drive; valid flags drop one later
    sequence por_low4;
        !POWER_ON_RESET_N [*4];
    endsequence
    sequence por_rise;
        !POWER_ON_RESET_N ##1 POWER_ON_RESET_N [*5];
    endsequence
    AST_OD_LOW: assert property (HARD_RESET_LINE_OUT == 1'b0) else $error("line out not low");
    AST_POR_DRIVE: assert property (por_low4 |-> HARD_RESET_LINE_OE) else $error("line free in POR");
    AST_POR_INVALID: assert property (por_low4 |=> !STRAPS_VALID && !WATCHDOG_ENABLE)
        else $error("config valid in POR");
    AST_CAP_BOOT: assert property (por_rise |-> STRAPS_VALID && BOOT_MODE == $past(BOOT_SELECT, 4))
        else $error("boot mode capture wrong");
    AST_CAP_FLAGS: assert property (por_rise |-> WATCHDOG_ENABLE == $past(WATCHDOG_STRAP, 4)
        && HOST_STROBE_ACTIVE_HIGH == $past(HOST_STROBE_POLARITY, 4)
        && HOST_PORT_8BIT == $past(HOST_WIDTH_SELECT, 4)) else $error("strap capture wrong");
    AST_HOLD: assert property (STRAPS_VALID [*3] |-> $stable({BOOT_MODE, HOST_STROBE_ACTIVE_HIGH,
        HOST_PORT_8BIT, WATCHDOG_ENABLE})) else $error("latched config moved");
    AST_WD_GATE: assert property (WATCHDOG_ENABLE |-> STRAPS_VALID) else $error("watchdog without capture");
    AST_B_DONE: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("bvalid stuck");
endmodule
bind reset_strap_latch strap_latch_monitor i_mon (.*);

// file: tb/testbench.sv
// Self-checking bench for the reset strap capture block
`timescale 1ns/1ps
module testbench;
    logic        MCLK, SYS_RST, POWER_ON_RESET_N, WATCHDOG_STRAP, HOST_STROBE_POLARITY, HOST_WIDTH_SELECT;
    logic        HARD_RESET_LINE_IN, HARD_RESET_LINE_OUT, HARD_RESET_LINE_OE, WATCHDOG_ENABLE;
    logic        HOST_STROBE_ACTIVE_HIGH, HOST_PORT_8BIT, STRAPS_VALID, por_hold, pull_low;
    logic [3:0]  BOOT_SELECT, BOOT_MODE, S_AXI_WSTRB;
    logic [6:0]  cfg;
    logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    int          err_total = 0, tests_run = 0, cyc = 0;
    board_supervisor i_board (.*);
    reset_strap_latch i_dut (.*);
    // ****
    // Checks and bus cycles
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 1'b0;
        chk({30'h0, S_AXI_BRESP}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 1'b0;
        chk(S_AXI_RDATA, ed);
        chk({30'h0, S_AXI_RRESP}, {30'h0, er});
    endtask
    // Config pins and status register must both show the captured straps
    task automatic chk_cfg(input logic [6:0] c);
        chk({24'h0, STRAPS_VALID, HOST_PORT_8BIT, HOST_STROBE_ACTIVE_HIGH, WATCHDOG_ENABLE, BOOT_MODE}, {25'h1, c});
        rd(8'h00, {25'h1, c}, 2'h0);
    endtask
    task automatic test_done;
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            test_done;
        end
    end
    // ****
    // Scenarios
    // ****
    initial begin
        {SYS_RST, por_hold, pull_low, cfg, S_AXI_WSTRB} = {2'b11, 1'b0, 7'h5A, 4'hF};
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        repeat (6) @(posedge MCLK);
        SYS_RST <= 1'b0;
        repeat (10) @(posedge MCLK);
        chk({31'h0, HARD_RESET_LINE_OE}, 32'h1);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h08, 32'h2, 2'h0);
        por_hold <= 1'b0;
        repeat (20) @(posedge MCLK);
        chk_cfg(7'h5A);
        cfg <= 7'h25;
        repeat (10) @(posedge MCLK);
        chk_cfg(7'h5A);
        rd(8'h08, 32'h3, 2'h0);
        wr(8'h08, 32'h2, 2'h0);
        rd(8'h08, 32'h1, 2'h0);
        wr(8'h04, 32'h1, 2'h0);
        rd(8'h04, 32'h1, 2'h0);
        chk({31'h0, HARD_RESET_LINE_OE}, 32'h1);
        rd(8'h08, 32'h2, 2'h0);
        wr(8'h04, 32'h0, 2'h0);
        repeat (4) @(posedge MCLK);
        wr(8'h08, 32'h2, 2'h0);
        pull_low <= 1'b1;
        repeat (4) @(posedge MCLK);
        chk({31'h0, HARD_RESET_LINE_OE}, 32'h0);
        rd(8'h08, 32'h2, 2'h0);
        pull_low <= 1'b0;
        wr(8'h00, 32'hFF, 2'h0);
        rd(8'h0C, 32'h0, 2'h2);
        wr(8'h0C, 32'h1, 2'h2);
        S_AXI_WSTRB <= 4'h0;
        wr(8'h04, 32'h1, 2'h0);
        S_AXI_WSTRB <= 4'hF;
        rd(8'h04, 32'h0, 2'h0);
        chk_cfg(7'h5A);
        por_hold <= 1'b1;
        repeat (8) @(posedge MCLK);
        chk({29'h0, HARD_RESET_LINE_OE, STRAPS_VALID, WATCHDOG_ENABLE}, 32'h4);
        por_hold <= 1'b0;
        repeat (20) @(posedge MCLK);
        chk_cfg(7'h25);
        test_done;
    end
endmodule
